// ---- sgc_bank.sv ----
// Purpose: global vlan/qos/sniff and host mii/storm control bank
// Assumes: apb slave, zero wait states, 8-bit registers in low bits
// Notes:   fabric hooks are simple per-frame decisions, registered
//
// Decided for this implementation: the APB slave port.
`timescale 1ns/100ps
`default_nettype none
`include "sgc_params.svh"

// Functional notes
// (RULE_01) vlan enable bit turns 802.1q vlan mode on, clear turns it off
// (RULE_02) software fills the vlan table before enabling vlan mode
// (RULE_03) igmp snoop bit sends every igmp frame to the host mii port
// (RULE_04) wfq with all queues busy shares bandwidth 8:4:2:1 for q3..q0
// (RULE_05) under wfq with any queue empty, highest non-empty queue gets one extra weight unit
// (RULE_06) wfq off: per-port strict priority bits choose the scheduling
// (RULE_07) sniff select 1 mirrors only when source and destination match
// (RULE_08) sniff select 0 mirrors when source or destination matches
// (RULE_09) host mii half duplex when set, full duplex when clear
// (RULE_10) host mii flow control enable, resets to one
// (RULE_11) host mii at 10 mbps when set, 100 mbps when clear
// (RULE_12) null vid replaced by the ingress port vid when enabled
// (RULE_13) bits 2:0 hold storm limit bits 10:8, reset zero
// (RULE_14) storm period is 67 ms at 100 mbps, 500 ms at 10 mbps
// (RULE_15) software keeps reserved bits at their reset values
// (RULE_16) next register holds storm limit bits 7:0, reset 0x63
// (RULE_17) count 64-byte blocks per port, drop over limit, restart per period
// (RULE_18) reserved bits read their reset value and ignore writes
module sgc_bank #(
  parameter int NPORT   = 3,
  parameter int CYC_100 = `SGC_CYC_100,
  parameter int CYC_10  = `SGC_CYC_10
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [11:0]      paddr,
  input  wire logic [31:0]      pwdata,
  input  wire logic [3:0]       pstrb,
  output logic [31:0]           prdata,
  output logic                  pready,
  output logic                  pslverr,
  input  wire logic             frm_valid,
  input  wire logic [1:0]       frm_src,
  input  wire logic [1:0]       frm_dst,
  input  wire logic             frm_igmp,
  input  wire logic             frm_bcast,
  input  wire logic [10:0]      frm_bytes,
  input  wire logic [11:0]      frm_vid,
  input  wire logic [11:0]      port_vid,
  input  wire logic [1:0]       sniff_port,
  input  wire logic [3:0]       q_busy,
  input  wire logic             q_strict,
  input  wire logic             q_grant_req,
  output sgc_pkg::sgc_qid_t     q_grant,
  output logic                  q_grant_vld,
  output logic                  frm_to_host,
  output logic                  frm_mirror,
  output logic                  frm_drop,
  output logic [11:0]           frm_vid_out,
  output logic                  vlan_mode,
  output logic                  host_half_duplex,
  output logic                  host_flow_ctrl,
  output logic                  host_10bt
);
  import sgc_pkg::*;

  logic [7:0]  ctrl3_q, ctrl3_d, ctrl4_q, ctrl4_d, ctrl5_q, ctrl5_d;
  logic [31:0] rdata_q, rdata_d;
  logic        err_q, err_d, rdy_q, rdy_d;
  logic        wr_en, acc, hit;
  logic [7:0]  rsel;

  // zero wait state: answer is registered in the setup cycle; a write lands
  // only at the access edge that completes the transfer
  assign acc   = psel && !penable;
  assign wr_en = psel && penable && rdy_q && pwrite && pstrb[0];
  always_comb begin
    hit  = 1'b1;
    rsel = 8'h00;
    case (paddr)
      `SGC_OFF_CTRL3:  rsel = ctrl3_q;
      `SGC_OFF_CTRL4:  rsel = ctrl4_q;
      `SGC_OFF_CTRL5:  rsel = ctrl5_q;
      `SGC_OFF_STATUS: rsel = {4'h0, q_busy};
      default:         hit  = 1'b0;
    endcase
  end

  always_comb begin
    ctrl3_d = ctrl3_q;
    ctrl4_d = ctrl4_q;
    ctrl5_d = ctrl5_q;
    rdata_d = rdata_q;
    err_d   = 1'b0;
    rdy_d   = acc;
    if (acc) begin
      err_d   = !hit;
      rdata_d = pwrite ? 32'h0000_0000 : {24'h00_0000, rsel};
    end
    if (wr_en && paddr == `SGC_OFF_CTRL3) begin
      // reserved bits keep reset value
      ctrl3_d = (pwdata[7:0] & `SGC_CTRL3_WMASK) | (`SGC_CTRL3_RESET & ~`SGC_CTRL3_WMASK);  // RULE_18
    end
    if (wr_en && paddr == `SGC_OFF_CTRL4) begin
      ctrl4_d = (pwdata[7:0] & `SGC_CTRL4_WMASK) | (`SGC_CTRL4_RESET & ~`SGC_CTRL4_WMASK);  // RULE_18
    end
    if (wr_en && paddr == `SGC_OFF_CTRL5) begin
      ctrl5_d = pwdata[7:0];  // RULE_16
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl3_q <= `SGC_CTRL3_RESET;
      ctrl4_q <= `SGC_CTRL4_RESET;  // RULE_10
      ctrl5_q <= `SGC_CTRL5_RESET;  // RULE_16
      rdata_q <= 32'h0000_0000;
      err_q   <= 1'b0;
      rdy_q   <= 1'b0;
    end else begin
      ctrl3_q <= ctrl3_d;
      ctrl4_q <= ctrl4_d;
      ctrl5_q <= ctrl5_d;
      rdata_q <= rdata_d;
      err_q   <= err_d;
      rdy_q   <= rdy_d;
    end
  end

  assign prdata  = rdata_q;
  assign pready  = rdy_q;
  assign pslverr = err_q;

  // mode outputs follow the register flops directly
  assign vlan_mode        = ctrl3_q[`SGC_B_VLAN];     // RULE_01
  assign host_half_duplex = ctrl4_q[`SGC_B_HALF];     // RULE_09
  assign host_flow_ctrl   = ctrl4_q[`SGC_B_FC];       // RULE_10
  assign host_10bt        = ctrl4_q[`SGC_B_10BT];     // RULE_11

  // storm metering, one meter per input port
  logic [10:0]      limit;
  logic [NPORT-1:0] pdrop;
  assign limit = {ctrl4_q[2:0], ctrl5_q};  // RULE_13
  for (genvar p = 0; p < NPORT; p++) begin : g_storm
    sgc_storm_port #(.CYC_100(CYC_100), .CYC_10(CYC_10)) u_meter (
      .pclk        (pclk),
      .presetn     (presetn),
      .is_10bt     (ctrl4_q[`SGC_B_10BT]),
      .limit       (limit),
      .frame_valid (frm_valid && frm_src == 2'(p)),
      .frame_reg   (frm_bcast),
      .frame_bytes (frm_bytes),
      .frame_drop  (pdrop[p]),
      .period_tick ()
    );
  end

  // per-frame decisions
  logic        host_q, host_d, mir_q, mir_d;
  logic        drop_q, drop_d;
  logic [11:0] vid_q, vid_d;
  logic        sm, dm;
  always_comb begin
    sm     = frm_src == sniff_port;
    dm     = frm_dst == sniff_port;
    host_d = frm_valid && frm_igmp && ctrl3_q[`SGC_B_IGMP];  // RULE_03
    // registered again so the pin comes straight from a flop
    drop_d = |pdrop;  // RULE_17
    if (ctrl3_q[`SGC_B_SNIFF]) begin
      mir_d = frm_valid && sm && dm;  // RULE_07
    end else begin
      mir_d = frm_valid && (sm || dm);  // RULE_08
    end
    vid_d = frm_vid;
    if (ctrl4_q[`SGC_B_NULLVID] && frm_vid == 12'h000) begin
      vid_d = port_vid;  // RULE_12
    end
  end

  // weighted fair queue credits, reloaded when all busy queues run dry
  logic [3:0] cr_q [4];
  logic [3:0] cr_d [4];
  sgc_qid_t   gnt_q, gnt_d, top;
  logic       gv_q, gv_d, any_cr;
  sgc_sched_t mode;
  always_comb begin
    mode = ctrl3_q[`SGC_B_WFQ] ? SGC_PRI_WFQ : SGC_PRI_STRICT;
    top  = q_busy[3] ? 2'd3 : q_busy[2] ? 2'd2 : q_busy[1] ? 2'd1 : 2'd0;
    for (int i = 0; i < 4; i++) begin
      cr_d[i] = cr_q[i];
    end
    gnt_d  = gnt_q;
    gv_d   = 1'b0;
    any_cr = 1'b0;
    for (int i = 0; i < 4; i++) begin
      if (q_busy[i] && cr_q[i] != 4'h0) any_cr = 1'b1;
    end
    if (q_grant_req && q_busy != 4'h0) begin
      gv_d = 1'b1;
      case (mode)
        SGC_PRI_WFQ: begin
          if (!any_cr) begin
            cr_d[3] = `SGC_WFQ_W3;  // RULE_04
            cr_d[2] = `SGC_WFQ_W2;
            cr_d[1] = `SGC_WFQ_W1;
            cr_d[0] = `SGC_WFQ_W0;
            // an empty queue donates one unit to the top busy queue
            if (q_busy != 4'hF) cr_d[top] = cr_d[top] + 4'h1;  // RULE_05
            for (int i = 0; i < 4; i++) begin
              if (!q_busy[i]) cr_d[i] = 4'h0;
            end
            gnt_d = top;
            cr_d[top] = cr_d[top] - 4'h1;
          end else begin
            gnt_d = top;
            for (int i = 0; i < 4; i++) begin
              if (q_busy[i] && cr_q[i] != 4'h0) gnt_d = 2'(i);
            end
            cr_d[gnt_d] = cr_q[gnt_d] - 4'h1;
          end
        end
        SGC_PRI_STRICT: begin
          // per-port strict bit picks strict priority, else round robin
          if (q_strict) begin
            gnt_d = top;  // RULE_06
          end else begin
            gnt_d = gnt_q - 2'd1;
            for (int i = 3; i >= 0; i--) begin
              if (q_busy[2'(gnt_q - 2'(i) - 2'd1)]) gnt_d = 2'(gnt_q - 2'(i) - 2'd1);  // RULE_06
            end
          end
        end
        default: gnt_d = top;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      host_q <= 1'b0;
      drop_q <= 1'b0;
      mir_q  <= 1'b0;
      vid_q  <= 12'h000;
      gnt_q  <= 2'd0;
      gv_q   <= 1'b0;
      for (int i = 0; i < 4; i++) cr_q[i] <= 4'h0;
    end else begin
      host_q <= host_d;
      drop_q <= drop_d;
      mir_q  <= mir_d;
      vid_q  <= vid_d;
      gnt_q  <= gnt_d;
      gv_q   <= gv_d;
      for (int i = 0; i < 4; i++) cr_q[i] <= cr_d[i];
    end
  end

  assign frm_to_host = host_q;
  assign frm_mirror  = mir_q;
  assign frm_vid_out = vid_q;
  assign frm_drop    = drop_q;  // RULE_17
  assign q_grant     = gnt_q;
  assign q_grant_vld = gv_q;
endmodule : sgc_bank
`default_nettype wire

// ---- sgc_bank_chk.sv ----
// Purpose: port assertions for the global control bank
// Assumes: zero wait apb, registered frame and grant outputs
// Notes:   write checks cover only bits that reach output pins
`timescale 1ns/100ps
`default_nettype none
`include "sgc_params.svh"
module sgc_bank_chk #(
  parameter int CYC_100 = 100,
  parameter int CYC_10  = 400
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        frm_valid,
  input wire logic        frm_bcast,
  input wire logic [11:0] frm_vid,
  input wire logic [11:0] frm_vid_out,
  input wire logic        frm_drop,
  input wire logic [3:0]  q_busy,
  input wire logic        q_grant_req,
  input wire logic        q_grant_vld,
  input wire logic        vlan_mode,
  input wire logic        host_half_duplex,
  input wire logic        host_flow_ctrl,
  input wire logic        host_10bt
);
  import sgc_pkg::*;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_access;
    psel && penable && pready;
  endsequence
  sequence s_wr(a);
    s_access ##0 (pwrite && pstrb[0] && paddr == a);
  endsequence
  a_ready_next: assert property (s_setup |=> pready)
    else $error("no ready after setup");
  a_ready_cause: assert property (pready |-> $past(psel && !penable))
    else $error("ready without setup");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_vlan_write: assert property (s_wr(`SGC_OFF_CTRL3) |=> vlan_mode == $past(pwdata[7]))
    else $error("vlan mode not written");
  a_host_write: assert property (s_wr(`SGC_OFF_CTRL4) |=>
    {host_half_duplex, host_flow_ctrl, host_10bt} == $past(pwdata[6:4]))
    else $error("host mii bits not written");
  a_vid_keep: assert property (frm_valid && frm_vid != 12'h000 |=>
    frm_vid_out == $past(frm_vid)) else $error("non-null vid altered");
  a_grant_due: assert property (q_grant_req && q_busy != 4'h0 |=> q_grant_vld)
    else $error("grant missing");
  a_grant_cause: assert property (q_grant_vld |-> $past(q_grant_req))
    else $error("grant without request");
  a_drop_cause: assert property (frm_drop |-> $past(frm_valid && frm_bcast, 2))
    else $error("drop without regulated frame");
endmodule : sgc_bank_chk
bind sgc_bank sgc_bank_chk #(.CYC_100(CYC_100), .CYC_10(CYC_10)) sgc_bank_chk_i (.*);
`default_nettype wire

// ---- sgc_bank_tb.sv ----
// Purpose: self-checking bench for the global control bank
// Assumes: zero wait apb, storm period shortened to 100 cycles at 100 mbps, 400 at 10 mbps
// Notes:   grant counts and random draws are kept as integers
`timescale 1ns/100ps
`default_nettype none
`include "sgc_params.svh"
module sgc_bank_tb;
  import sgc_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr, frm_vid, port_vid, frm_vid_out;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  pstrb, q_busy;
  logic        frm_valid, frm_igmp, frm_bcast, q_strict, q_grant_req, q_grant_vld;
  logic        frm_to_host, frm_mirror, frm_drop, vlan_mode;
  logic        host_half_duplex, host_flow_ctrl, host_10bt;
  logic [1:0]  frm_src, frm_dst, sniff_port;
  logic [10:0] frm_bytes;
  sgc_qid_t    q_grant;
  int          miscompares, checks_done, cyc, i, k, e, v;
  int          cnt[4];
  sgc_bank #(.CYC_100(100), .CYC_10(400)) sgc_bank_i (.*);
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 8000) begin
      miscompares++;
      end_of_test();
    end
  end
  task end_of_test;
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : end_of_test
  task chk(input logic [31:0] g, input logic [31:0] x);
    checks_done++;
    if (g !== x) begin
      miscompares++;
      $display("mismatch at %0t got %h exp %h", $time, g, x);
    end
  endtask : chk
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task rdchk(input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0000_0000, 4'h0);
    chk(rd, x);
    chk(err, 0);
  endtask : rdchk
  task fpulse;
    @(posedge pclk);
    frm_valid <= 1'b1;
    @(posedge pclk);
    frm_valid <= 1'b0;
    @(posedge pclk);
  endtask : fpulse
  task grant;
    @(posedge pclk);
    q_grant_req <= 1'b1;
    @(posedge pclk);
    q_grant_req <= 1'b0;
    @(posedge pclk);
    chk(q_grant_vld, 1);
    cnt[q_grant]++;
  endtask : grant
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, pstrb, frm_valid, frm_src, frm_dst} = '0;
    {frm_igmp, frm_bcast, frm_bytes, frm_vid, port_vid, sniff_port} = '0;
    {q_busy, q_strict, q_grant_req, miscompares, checks_done, cyc} = '0;
    void'($urandom(32'h5348_6f46));
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rdchk(`SGC_OFF_CTRL3, 32'h0000_0000);
    rdchk(`SGC_OFF_CTRL4, 32'h0000_0020);
    rdchk(`SGC_OFF_CTRL5, 32'h0000_0063);
    chk(host_flow_ctrl, 1);
    apb(1'b1, `SGC_OFF_CTRL3, 32'h0000_0008, 4'h1);
    for (k = 0; k < 2; k++) begin
      q_busy <= k ? 4'hB : 4'hF;
      cnt = '{0, 0, 0, 0};
      repeat (k ? 12 : 15) grant();
      for (i = 0; i < 4; i++)
        chk(cnt[i], q_busy[i] ? (1 << i) + (k && i == 3) : 0);
    end
    rdchk(`SGC_OFF_STATUS, 32'h0000_000B);
    apb(1'b1, `SGC_OFF_CTRL3, 32'h0000_0000, 4'h1);
    q_strict <= 1'b1;
    repeat (6) begin
      v = $urandom_range(1, 15);
      q_busy <= v[3:0];
      for (i = 0; i < 4; i++) if (v[i]) e = i;
      grant();
      chk(q_grant, e);
    end
    q_strict <= 1'b0;
    q_busy <= 4'hF;
    cnt = '{0, 0, 0, 0};
    repeat (4) grant();
    for (i = 0; i < 4; i++) chk(cnt[i], 1);
    apb(1'b1, `SGC_OFF_CTRL3, 32'h0000_00C9, 4'h1);
    apb(1'b1, `SGC_OFF_CTRL3, 32'h0000_0000, 4'h0);
    rdchk(`SGC_OFF_CTRL3, 32'h0000_00C9);
    chk(vlan_mode, 1);
    apb(1'b0, 12'h0FC, 32'h0000_0000, 4'h0);
    chk(err, 1);
    sniff_port <= 2'd1;
    for (k = 0; k < 4; k++) begin
      apb(1'b1, `SGC_OFF_CTRL3, (k[1] << 6) | k[0], 4'h1);
      apb(1'b1, `SGC_OFF_CTRL4, k[0] << 3, 4'h1);
      for (i = 0; i < 4; i++) begin
        v = $urandom;
        frm_src <= i[0] ? 2'd1 : 2'd2;
        frm_dst <= i[1] ? 2'd1 : 2'd0;
        frm_igmp <= v[12];
        frm_vid <= i[0] ? 12'h000 : (v[11:0] | 12'h001);
        port_vid <= v[27:16];
        fpulse();
        chk(frm_to_host, k[1] & v[12]);
        chk(frm_mirror, k[0] ? i == 3 : i != 0);
        chk(frm_vid_out, (i[0] && k[0]) ? v[27:16] : frm_vid);
      end
    end
    repeat (4) begin
      v = $urandom;
      apb(1'b1, `SGC_OFF_CTRL4, v & 32'h0000_007F, 4'h1);
      rdchk(`SGC_OFF_CTRL4, v & 32'h0000_007F);
      chk({host_half_duplex, host_flow_ctrl, host_10bt}, v[6:4]);
    end
    // second reset puts the storm period timer at a known phase
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rdchk(`SGC_OFF_CTRL4, 32'h0000_0020);
    apb(1'b1, `SGC_OFF_CTRL5, 32'h0000_0002, 4'h1);
    frm_bcast <= 1'b1;
    frm_src <= 2'd0;
    for (i = 0; i < 3; i++) begin
      if (i == 2) repeat (110) @(posedge pclk);
      frm_bytes <= i ? 11'd1 : 11'd200;
      fpulse();
      @(posedge pclk);
      chk(frm_drop, i == 1);
    end
    end_of_test();
  end
endmodule : sgc_bank_tb
`default_nettype wire

// ---- sgc_params.svh ----
// Purpose: constants for the switch global control bank
// Assumes: apb byte addresses, 8-bit registers in the low lanes
// Notes:   timing counts derive from the 25 MHz pclk
`ifndef SGC_PARAMS_SVH
`define SGC_PARAMS_SVH

`define SGC_OFF_CTRL3        12'h0014
`define SGC_OFF_CTRL4        12'h0018
`define SGC_OFF_CTRL5        12'h001C
`define SGC_OFF_STATUS       12'h0020
`define SGC_CTRL3_RESET      8'h00
`define SGC_CTRL3_WMASK      8'hC9
`define SGC_CTRL4_RESET      8'h20
`define SGC_CTRL4_WMASK      8'h7F
`define SGC_CTRL5_RESET      8'h63
`define SGC_B_VLAN           7
`define SGC_B_IGMP           6
`define SGC_B_WFQ            3
`define SGC_B_SNIFF          0
`define SGC_B_HALF           6
`define SGC_B_FC             5
`define SGC_B_10BT           4
`define SGC_B_NULLVID        3
`define SGC_CLK_HZ           25000000
`define SGC_PERIOD_100_MS    67
`define SGC_PERIOD_10_MS     500
`define SGC_CYC_100          ((`SGC_CLK_HZ / 1000) * `SGC_PERIOD_100_MS)
`define SGC_CYC_10           ((`SGC_CLK_HZ / 1000) * `SGC_PERIOD_10_MS)
`define SGC_BLOCK_BYTES      64
`define SGC_WFQ_W3           4'h8
`define SGC_WFQ_W2           4'h4
`define SGC_WFQ_W1           4'h2
`define SGC_WFQ_W0           4'h1

`endif

// ---- sgc_pkg.sv ----
// Purpose: shared types for the switch global control bank
// Assumes: nothing beyond the header
// Notes:   types only
package sgc_pkg;
  typedef logic [1:0] sgc_qid_t;
  typedef enum logic [1:0] {
    SGC_PRI_STRICT = 2'b01,
    SGC_PRI_WFQ    = 2'b10
  } sgc_sched_t;
endpackage : sgc_pkg

// ---- sgc_storm_port.sv ----
// Purpose: per-port broadcast storm meter
// Assumes: frame_bytes carries the frame size while frame_valid pulses
// Notes:   one instance per input port
`timescale 1ns/100ps
`default_nettype none
`include "sgc_params.svh"
module sgc_storm_port #(
  parameter int CYC_100 = `SGC_CYC_100,
  parameter int CYC_10  = `SGC_CYC_10
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        is_10bt,
  input  wire logic [10:0] limit,
  input  wire logic        frame_valid,
  input  wire logic        frame_reg,
  input  wire logic [10:0] frame_bytes,
  output logic             frame_drop,
  output logic             period_tick
);
  import sgc_pkg::*;
  logic [24:0] tmr_q, tmr_d;
  logic [11:0] cnt_q, cnt_d;
  logic        drop_q, drop_d;
  logic        tick_q, tick_d;
  logic [5:0]  blocks;

  // a partial block counts as a whole one
  assign blocks = 6'(({1'b0, frame_bytes} + 12'd63) >> 6);

  always_comb begin
    tmr_d  = tmr_q + 25'd1;
    tick_d = 1'b0;
    cnt_d  = cnt_q;
    drop_d = 1'b0;
    if (tmr_q >= 25'(is_10bt ? CYC_10 - 1 : CYC_100 - 1)) begin  // RULE_14
      tmr_d  = '0;
      tick_d = 1'b1;
      cnt_d  = '0;  // RULE_17
      // a frame on the boundary opens the new period instead of being lost
      if (frame_valid && frame_reg) begin
        if (limit == 11'd0) begin
          drop_d = 1'b1;  // RULE_17
        end else begin
          cnt_d = {6'd0, blocks};  // RULE_13
        end
      end
    end else if (frame_valid && frame_reg) begin
      if (cnt_q >= {1'b0, limit}) begin
        drop_d = 1'b1;  // RULE_17
      end else begin
        cnt_d = cnt_q + {6'd0, blocks};  // RULE_13
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tmr_q  <= '0;
      cnt_q  <= '0;
      drop_q <= 1'b0;
      tick_q <= 1'b0;
    end else begin
      tmr_q  <= tmr_d;
      cnt_q  <= cnt_d;
      drop_q <= drop_d;
      tick_q <= tick_d;
    end
  end

  assign frame_drop  = drop_q;
  assign period_tick = tick_q;
endmodule : sgc_storm_port
`default_nettype wire
